// File: rtl/dero_pkg.sv
// Constants shared by the device error-objects register bank.
// ---------------------------------------------------------------------------
// Behaviour
// - A fault category that is present sets its error-flag bit.
// - The flag bit clears by itself once its fault has gone.
// - Flag bits: general, current, voltage, temp, link, profile, zero, vendor.
// - Every recorded fault also stores a 32-bit code in the history stack.
// - Device kind word bits 23..16: 2 brushless, 4 stepper, 6 both.
// - Device kind word bits 15..0 read the drive profile number 0192 hex.
// - The history stack holds at most eight entries.
// - Host writes to read-only objects leave them unchanged.
// - At start-up every object takes its preset; flags and count are zero.
// - New fault enters entry 1, entries 1..7 move down, oldest is dropped.
// - Host writing zero to the entry count clears the history count.
// - Reading a stack entry while the stack is empty answers abort 08000024.
// - Entry: number in 31..24, class in 23..16, code in 15..0.
// ---------------------------------------------------------------------------
package dero_pkg;

  // -------------------------------------------------------------------------
  // Bus and register map (word indices; byte address is four times these)
  // -------------------------------------------------------------------------
  localparam int          ADDR_W       = 16;
  localparam int          IDX_W        = 14;
  localparam logic [13:0] IDX_KIND     = 14'h1000;
  localparam logic [13:0] IDX_FLAGS    = 14'h1001;
  localparam logic [13:0] IDX_COUNT    = 14'h1003;
  localparam logic [13:0] IDX_ENTRY    = 14'h1100; // Entries 1..8 follow
  localparam logic [13:0] IDX_IRQ_STAT = 14'h1200;
  localparam logic [13:0] IDX_IRQ_CLR  = 14'h1201;
  localparam logic [13:0] IDX_IRQ_EN   = 14'h1202;

  // -------------------------------------------------------------------------
  // AXI4-Lite responses
  // -------------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // -------------------------------------------------------------------------
  // Device kind word fields
  // -------------------------------------------------------------------------
  localparam logic [7:0]  MOTOR_BLDC     = 8'h02;
  localparam logic [7:0]  MOTOR_STEPPER  = 8'h04;
  localparam logic [7:0]  MOTOR_BOTH     = 8'h06;
  localparam logic [15:0] DRIVE_PROFILE  = 16'h0192;
  localparam int          KIND_MOTOR_LSB = 16;
  localparam int          KIND_DRIVE_PROFILE_FAULT_FLAG_LSB  = 0;

  // -------------------------------------------------------------------------
  // Fault category flag positions
  // -------------------------------------------------------------------------
  localparam int         FLAG_W                = 8;
  localparam int         general_fault_flag    = 0;
  localparam int         overcurrent_flag      = 1;
  localparam int         supply_fault_flag     = 2;
  localparam int         thermal_fault_flag    = 3;
  localparam int         link_fault_flag       = 4;
  localparam int         drive_profile_fault_flag = 5;
  localparam int         unused_zero_bit       = 6;
  localparam int         vendor_fault_flag     = 7;
  localparam logic [7:0] FLAG_USED_MASK        = 8'hbf;
  localparam logic [7:0] FLAGS_RST             = 8'h00;

  // -------------------------------------------------------------------------
  // History stack
  // -------------------------------------------------------------------------
  localparam int          STACK_DEPTH   = 8;
  localparam int          COUNT_W       = 8;
  localparam logic [7:0]  COUNT_RST     = 8'h00;
  localparam logic [31:0] ENTRY_RST     = 32'h00000000;
  localparam int          ENT_NUM_LSB   = 24;
  localparam int          ENT_CLASS_LSB = 16;
  localparam int          ENT_CODE_LSB  = 0;
  localparam logic [31:0] ABORT_EMPTY   = 32'h08000024;

  // -------------------------------------------------------------------------
  // Interrupt status bits
  // -------------------------------------------------------------------------
  localparam int        IRQ_W      = 2;
  localparam int        IRQ_RECORD = 0; // A fault was pushed on the stack
  localparam int        IRQ_RAISE  = 1; // A category flag went high
  localparam logic [1:0] IRQ_RST   = 2'h0;

endpackage : dero_pkg

// File: rtl/dero_sync.sv
// Two-stage synchroniser for the live fault condition pins.
`timescale 1ns/100ps
`default_nettype none

module dero_sync #(
  parameter int W = 8
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } dero_sync_t;

  dero_sync_t r_q;
  dero_sync_t r_d;

  // First stage feeds only the second stage
  always_comb begin
    r_d    = r_q;
    r_d.s1 = d;
    r_d.s2 = r_q.s1;
  end

  // Synchronous reset clears both stages
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign q = r_q.s2;

endmodule : dero_sync
`default_nettype wire

// File: rtl/dero_stack.sv
// Fault history stack: newest entry first, saturating entry count.
`timescale 1ns/100ps
`default_nettype none

module dero_stack
  import dero_pkg::*;
#(
  parameter int DEPTH = dero_pkg::STACK_DEPTH
) (
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  input  wire logic                         push,
  input  wire logic [31:0]                  code,
  input  wire logic                         clr,
  output logic      [dero_pkg::COUNT_W-1:0] count,
  output logic      [DEPTH-1:0][31:0]       entries
);

  typedef struct packed {
    logic [COUNT_W-1:0]     cnt;
    logic [DEPTH-1:0][31:0] ent;
  } dero_stack_t;

  localparam logic [COUNT_W-1:0] CNT_MAX = COUNT_W'(DEPTH);

  dero_stack_t r_q;
  dero_stack_t r_d;

  // Clear restarts the count; a push in the same cycle still counts
  always_comb begin
    r_d = r_q;
    if (clr) begin
      r_d.cnt = COUNT_RST;
    end
    if (push) begin
      for (int i = DEPTH - 1; i > 0; i--) begin
        r_d.ent[i] = r_q.ent[i-1];
      end
      r_d.ent[0] = code;
      if (r_d.cnt < CNT_MAX) begin
        r_d.cnt = r_d.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_q.cnt <= COUNT_RST;
      r_q.ent <= {DEPTH{ENTRY_RST}};
    end else begin
      r_q <= r_d;
    end
  end

  assign count   = r_q.cnt;
  assign entries = r_q.ent;

  a_push_shift: assert property (@(posedge aclk) disable iff (!aresetn)
    push |=> (r_q.ent[0] == $past(code)) && (r_q.ent[1] == $past(r_q.ent[0])))
    else $error("stack push did not shift entries");

  a_count_cap: assert property (@(posedge aclk) disable iff (!aresetn)
    r_q.cnt <= CNT_MAX)
    else $error("stack count above depth");

  a_count_sat: assert property (@(posedge aclk) disable iff (!aresetn)
    (push && !clr && r_q.cnt == CNT_MAX) |=> r_q.cnt == CNT_MAX)
    else $error("saturated count moved");

endmodule : dero_stack
`default_nettype wire

// File: rtl/dero_regs.sv
// Device error objects: kind word, fault flags, history stack, AXI4-Lite.
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none

module dero_regs
  import dero_pkg::*;
#(
  parameter logic [7:0] MOTOR_KIND = dero_pkg::MOTOR_STEPPER
) (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // Live fault conditions, asynchronous
  input  wire logic [dero_pkg::FLAG_W-1:0] fault_live,
  // Fault record from local logic, same clock
  input  wire logic                        rec_valid,
  input  wire logic [7:0]                  rec_number,
  input  wire logic [7:0]                  rec_class,
  input  wire logic [15:0]                 rec_code,
  // AXI4-Lite slave
  input  wire logic [dero_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic      [1:0]                  s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [dero_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic      [31:0]                 s_axi_rdata,
  output logic      [1:0]                  s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  output logic                             irq
);

  // -------------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------------
  typedef struct packed {
    logic              aw_rdy;
    logic              w_rdy;
    logic              aw_have;
    logic              w_have;
    logic [IDX_W-1:0]  aw_idx;
    logic [31:0]       wdata;
    logic              wstb0;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              ar_rdy;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic [FLAG_W-1:0] flags;
    logic [IRQ_W-1:0]  stat;
    logic [IRQ_W-1:0]  en;
    logic              irq;
  } dero_regs_t;

  // Fixed identification word; motor kind is a build choice
  localparam logic [31:0] KIND_WORD =
    (32'(MOTOR_KIND) << KIND_MOTOR_LSB) |
    (32'(DRIVE_PROFILE) << KIND_DRIVE_PROFILE_FAULT_FLAG_LSB);

  dero_regs_t                   r_q;
  dero_regs_t                   r_d;
  logic [FLAG_W-1:0]            live_s;
  logic [COUNT_W-1:0]           count;
  logic [STACK_DEPTH-1:0][31:0] entries;
  logic [31:0]                  rec_word;
  logic                         wr_go;
  logic                         cnt_clr;
  logic [IDX_W-1:0]             ar_idx;
  logic                         ar_go;

  // -------------------------------------------------------------------------
  // Sub-blocks
  // -------------------------------------------------------------------------

  // Pins change at any time, so they pass two flops before use
  dero_sync #(
    .W (FLAG_W)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (fault_live),
    .q       (live_s)
  );

  // Entry layout: number, class, code
  assign rec_word = (32'(rec_number) << ENT_NUM_LSB) |
                    (32'(rec_class) << ENT_CLASS_LSB) |
                    (32'(rec_code) << ENT_CODE_LSB);

  dero_stack #(
    .DEPTH (STACK_DEPTH)
  ) u_stack (
    .aclk    (aclk),
    .aresetn (aresetn),
    .push    (rec_valid),
    .code    (rec_word),
    .clr     (cnt_clr),
    .count   (count),
    .entries (entries)
  );

  // -------------------------------------------------------------------------
  // Bus decode helpers
  // -------------------------------------------------------------------------

  // Write runs once both halves are in and no response is pending
  assign wr_go  = r_q.aw_have & r_q.w_have & ~r_q.bvalid;
  assign ar_idx = s_axi_araddr[IDX_W+1:2];
  assign ar_go  = s_axi_arvalid & r_q.ar_rdy;
  // Only zero is accepted for the count; other values are dropped
  assign cnt_clr = wr_go && (r_q.aw_idx == IDX_COUNT) && r_q.wstb0 &&
                   (r_q.wdata[7:0] == 8'h00);

  // -------------------------------------------------------------------------
  // Next state
  // -------------------------------------------------------------------------
  always_comb begin
    r_d = r_q;

    // Live fault categories; the unused bit is forced low
    r_d.flags = live_s & FLAG_USED_MASK;

    // Write address and data are taken in either order
    if (s_axi_awvalid && r_q.aw_rdy) begin
      r_d.aw_have = 1'b1;
      r_d.aw_idx  = s_axi_awaddr[IDX_W+1:2];
    end
    if (s_axi_wvalid && r_q.w_rdy) begin
      r_d.w_have = 1'b1;
      r_d.wdata  = s_axi_wdata;
      r_d.wstb0  = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready) begin
      r_d.bvalid = 1'b0;
    end

    // Perform the write; read-only objects accept and ignore it
    if (wr_go) begin
      r_d.aw_have = 1'b0;
      r_d.w_have  = 1'b0;
      r_d.bvalid  = 1'b1;
      r_d.bresp   = RESP_OKAY;
      case (r_q.aw_idx)
        IDX_KIND, IDX_FLAGS, IDX_COUNT, IDX_IRQ_STAT: begin
          r_d.bresp = RESP_OKAY;
        end
        IDX_IRQ_CLR: begin
          if (r_q.wstb0) begin
            r_d.stat = r_q.stat & ~r_q.wdata[IRQ_W-1:0];
          end
        end
        IDX_IRQ_EN: begin
          if (r_q.wstb0) begin
            r_d.en = r_q.wdata[IRQ_W-1:0];
          end
        end
        default: begin
          if (r_q.aw_idx[IDX_W-1:3] != IDX_ENTRY[IDX_W-1:3]) begin
            r_d.bresp = RESP_DECERR;
          end
        end
      endcase
    end
    r_d.aw_rdy = ~r_d.aw_have & ~r_d.bvalid;
    r_d.w_rdy  = ~r_d.w_have & ~r_d.bvalid;

    // Events win over a clear in the same cycle
    if (rec_valid) begin
      r_d.stat[IRQ_RECORD] = 1'b1;
    end
    if (|(r_d.flags & ~r_q.flags)) begin
      r_d.stat[IRQ_RAISE] = 1'b1;
    end
    r_d.irq = |(r_d.stat & r_d.en);

    // Read: answer one cycle after the address is taken
    if (s_axi_rvalid && s_axi_rready) begin
      r_d.rvalid = 1'b0;
      r_d.ar_rdy = 1'b1;
    end
    if (ar_go) begin
      r_d.ar_rdy = 1'b0;
      r_d.rvalid = 1'b1;
      r_d.rresp  = RESP_OKAY;
      r_d.rdata  = 32'h00000000;
      case (ar_idx)
        IDX_KIND: begin
          r_d.rdata = KIND_WORD;
        end
        IDX_FLAGS: begin
          r_d.rdata = 32'(r_q.flags);
        end
        IDX_COUNT: begin
          r_d.rdata = 32'(count);
        end
        IDX_IRQ_STAT: begin
          r_d.rdata = 32'(r_q.stat);
        end
        IDX_IRQ_CLR: begin
          r_d.rdata = 32'h00000000;
        end
        IDX_IRQ_EN: begin
          r_d.rdata = 32'(r_q.en);
        end
        default: begin
          if (ar_idx[IDX_W-1:3] != IDX_ENTRY[IDX_W-1:3]) begin
            r_d.rresp = RESP_DECERR;
          end else if (count == COUNT_RST) begin
            r_d.rresp = RESP_SLVERR;
            r_d.rdata = ABORT_EMPTY;
          end else begin
            r_d.rdata = entries[ar_idx[2:0]];
          end
        end
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------------------

  // Presets put the bank in a known safe state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_q        <= '0;
      r_q.flags  <= FLAGS_RST;
      r_q.stat   <= IRQ_RST;
      r_q.en     <= IRQ_RST;
      r_q.aw_rdy <= 1'b1;
      r_q.w_rdy  <= 1'b1;
      r_q.ar_rdy <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  // -------------------------------------------------------------------------
  // Outputs, all from flops
  // -------------------------------------------------------------------------
  assign s_axi_awready = r_q.aw_rdy;
  assign s_axi_wready  = r_q.w_rdy;
  assign s_axi_bvalid  = r_q.bvalid;
  assign s_axi_bresp   = r_q.bresp;
  assign s_axi_arready = r_q.ar_rdy;
  assign s_axi_rvalid  = r_q.rvalid;
  assign s_axi_rdata   = r_q.rdata;
  assign s_axi_rresp   = r_q.rresp;
  assign irq           = r_q.irq;

  // -------------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------------
  a_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
    (|(live_s & ~r_q.flags & FLAG_USED_MASK)) |=>
      ((r_q.flags & $past(live_s) & FLAG_USED_MASK) ==
       ($past(live_s) & FLAG_USED_MASK)))
    else $error("present fault did not set its flag");

  a_flag_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (|(r_q.flags & ~live_s)) |=> ((r_q.flags & ~$past(live_s)) == 8'h00))
    else $error("flag stayed set after fault went");

  a_zero_bit: assert property (@(posedge aclk) disable iff (!aresetn)
    r_q.flags[unused_zero_bit] == 1'b0)
    else $error("unused flag bit set");

  a_kind_read: assert property (@(posedge aclk) disable iff (!aresetn)
    (ar_go && ar_idx == IDX_KIND) |=>
      (s_axi_rvalid && s_axi_rdata[31:16] == 16'(MOTOR_KIND) &&
       s_axi_rdata[15:0] == DRIVE_PROFILE))
    else $error("kind word read wrong");

  a_empty_abort: assert property (@(posedge aclk) disable iff (!aresetn)
    (ar_go && ar_idx[IDX_W-1:3] == IDX_ENTRY[IDX_W-1:3] &&
     count == COUNT_RST) |=>
      (s_axi_rresp == RESP_SLVERR && s_axi_rdata == ABORT_EMPTY))
    else $error("empty stack read not refused");

  a_count_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (cnt_clr && !rec_valid) |=> count == COUNT_RST)
    else $error("count not cleared by zero write");

  a_ro_entry: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_go && !rec_valid) |=> $stable(entries))
    else $error("bus write altered a stack entry");

  a_reset_preset: assert property (@(posedge aclk)
    !aresetn |=> (count == COUNT_RST && r_q.flags == FLAGS_RST && !irq))
    else $error("preset values missing after reset");

  a_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go |=> s_axi_bvalid ##0 (!s_axi_awready && !s_axi_wready))
    else $error("write response late");

endmodule : dero_regs
`default_nettype wire

// File: tb/dero_host.sv
// Fieldbus host model: AXI4-Lite master making single object accesses.
`timescale 1ns/100ps
`default_nettype none

module dero_host (
  input  wire logic        aclk,
  output logic      [15:0] s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic      [31:0] s_axi_wdata,
  output logic      [3:0]  s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic      [15:0] s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  // ------------------------------------------------------------
  // Idle bus at time zero
  // ------------------------------------------------------------
  initial begin
    s_axi_awaddr  = 16'hffff;
    s_axi_awvalid = 1'b0;
    s_axi_wdata   = 32'hffffffff;
    s_axi_wstrb   = 4'hf;
    s_axi_wvalid  = 1'b0;
    s_axi_bready  = 1'b0;
    s_axi_araddr  = 16'hffff;
    s_axi_arvalid = 1'b0;
    s_axi_rready  = 1'b0;
  end

  // One write; any value may go to the count, only zero is accepted there
  // Payload is inverted once taken, so a stale address never lingers
  task automatic wr(input logic [15:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    bit done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr  <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata  <= ~d;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : wr

  // One read; data and response taken at the handshake edge
  task automatic rd(input logic [15:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    bit done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr  <= ~a;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : rd
endmodule : dero_host
`default_nettype wire

// File: tb/tb_top.sv
// Testbench for the device error-objects register bank.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import dero_pkg::*;
  localparam logic [15:0] A_KIND = {IDX_KIND, 2'b00};
  localparam logic [15:0] A_FLG  = {IDX_FLAGS, 2'b00};
  localparam logic [15:0] A_CNT  = {IDX_COUNT, 2'b00};
  localparam logic [15:0] A_ENT  = {IDX_ENTRY, 2'b00};
  localparam logic [15:0] A_ST   = {IDX_IRQ_STAT, 2'b00};
  localparam logic [15:0] A_CLR  = {IDX_IRQ_CLR, 2'b00};
  localparam logic [15:0] A_EN   = {IDX_IRQ_EN, 2'b00};

  logic        aclk, aresetn, rec_valid, irq;
  logic [7:0]  fault_live, rec_number, rec_class;
  logic [15:0] rec_code, awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  int          n_fail, checked;

  // ------------------------------------------------------------
  // Clock, design and host
  // ------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  dero_regs dut (.aclk(aclk), .aresetn(aresetn), .fault_live(fault_live),
    .rec_valid(rec_valid), .rec_number(rec_number), .rec_class(rec_class),
    .rec_code(rec_code), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .irq(irq));

  dero_host h (.aclk(aclk), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  // ------------------------------------------------------------
  // Checking helpers
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Read and compare both data and response
  task automatic rchk(input string nm, input logic [15:0] a,
                      input logic [31:0] exp, input logic [1:0] er);
    logic [31:0] d;
    h.rd(a, d, r);
    chk(nm, d, exp);
    chk({nm, " resp"}, {30'h0, r}, {30'h0, er});
  endtask : rchk

  // Write and compare the response
  task automatic wchk(input string nm, input logic [15:0] a,
                      input logic [31:0] d, input logic [1:0] er);
    h.wr(a, d, r);
    chk({nm, " bresp"}, {30'h0, r}, {30'h0, er});
  endtask : wchk

  // Expected record word for the i-th push
  function automatic logic [31:0] rec_word(input int i);
    return {i[7:0], 8'h10 + i[7:0], 16'ha000 + i[15:0]};
  endfunction : rec_word

  // Back-to-back record pushes, numbered 1..n
  task automatic push_n(input int n);
    logic [31:0] w;
    for (int i = 1; i <= n; i++) begin
      w = rec_word(i);
      @(posedge aclk);
      rec_valid  <= 1'b1;
      rec_number <= w[31:24];
      rec_class  <= w[23:16];
      rec_code   <= w[15:0];
    end
    @(posedge aclk);
    rec_valid <= 1'b0;
  endtask : push_n

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim

  // Watchdog: the tests need well under a thousand cycles
  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    end_sim();
  end

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    n_fail = 0;
    checked = 0;
    aresetn = 1'b0;
    fault_live = 8'h00;
    rec_valid = 1'b0;
    rec_number = 8'h00;
    rec_class = 8'h00;
    rec_code = 16'h0000;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;

    rchk("kind", A_KIND, {8'h00, MOTOR_STEPPER, 16'h0192}, RESP_OKAY);
    rchk("flags", A_FLG, 32'h0, RESP_OKAY);
    rchk("count", A_CNT, 32'h0, RESP_OKAY);
    rchk("empty entry", A_ENT, 32'h08000024, RESP_SLVERR);
    rchk("unmapped", 16'h2000, 32'h0, RESP_DECERR);
    wchk("unmapped", 16'h2000, 32'h1, RESP_DECERR);
    wchk("kind wr", A_KIND, 32'h0, RESP_OKAY);
    wchk("flags wr", A_FLG, 32'hff, RESP_OKAY);
    rchk("kind kept", A_KIND, {8'h00, MOTOR_STEPPER, 16'h0192}, RESP_OKAY);
    rchk("flags kept", A_FLG, 32'h0, RESP_OKAY);
    $display("test reset_and_access done");

    // Each category alone; the spare bit must never show, even if driven
    for (int i = 0; i < 8; i++) begin
      @(posedge aclk);
      fault_live <= 8'h01 << i;
      repeat (5) @(posedge aclk);
      rchk("flag set", A_FLG, (i == 6) ? 32'h0 : 32'h1 << i, RESP_OKAY);
      @(posedge aclk);
      fault_live <= 8'h00;
      repeat (5) @(posedge aclk);
      rchk("flag gone", A_FLG, 32'h0, RESP_OKAY);
    end
    rchk("raise status", A_ST, 32'h2, RESP_OKAY);
    wchk("clear all", A_CLR, 32'h3, RESP_OKAY);
    $display("test fault_flags done");

    // Nine pushes: count stops at eight, oldest record dropped
    push_n(9);
    rchk("count sat", A_CNT, 32'h8, RESP_OKAY);
    for (int k = 1; k <= 8; k++) begin
      rchk("entry", A_ENT + 16'(4 * (k - 1)), rec_word(10 - k), RESP_OKAY);
    end
    wchk("entry wr", A_ENT, 32'h0, RESP_OKAY);
    rchk("entry kept", A_ENT, rec_word(9), RESP_OKAY);
    $display("test history_stack done");

    // Count clear: nonzero ignored, zero restarts counting
    wchk("count 5", A_CNT, 32'h5, RESP_OKAY);
    rchk("count kept", A_CNT, 32'h8, RESP_OKAY);
    wchk("count 0", A_CNT, 32'h0, RESP_OKAY);
    rchk("count clr", A_CNT, 32'h0, RESP_OKAY);
    rchk("cleared entry", A_ENT, 32'h08000024, RESP_SLVERR);
    push_n(1);
    rchk("count one", A_CNT, 32'h1, RESP_OKAY);
    rchk("fresh entry", A_ENT, rec_word(1), RESP_OKAY);
    $display("test count_clear done");

    // Interrupt: enabled, cleared, then masked
    wchk("clr", A_CLR, 32'h3, RESP_OKAY);
    wchk("en", A_EN, 32'h1, RESP_OKAY);
    rchk("en rb", A_EN, 32'h1, RESP_OKAY);
    push_n(1);
    repeat (2) @(posedge aclk);
    chk("irq on", {31'h0, irq}, 32'h1);
    wchk("clr rec", A_CLR, 32'h1, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("irq off", {31'h0, irq}, 32'h0);
    rchk("status", A_ST, 32'h0, RESP_OKAY);
    wchk("mask", A_EN, 32'h0, RESP_OKAY);
    push_n(1);
    repeat (2) @(posedge aclk);
    chk("irq masked", {31'h0, irq}, 32'h0);
    rchk("status held", A_ST, 32'h1, RESP_OKAY);
    rchk("clr reads 0", A_CLR, 32'h0, RESP_OKAY);
    $display("test interrupt done");
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
